// File: hw/option_byte_clock_reset_config.v
// How it works
// - Hold CPU in reset or halt exit 4096 cycles if bit6=0, 256 if 1.
// - Bits 5:4 select resonator (00) or external source (11); others reserved.
// - Resonator: bits 3:1 set oscillator current for 1-2 to 8-16 MHz.
// - Non-resonator: bits 3:1 select the normal operating frequency range.
// - Bit 0 low enables the times-two PLL; high bypasses it.
// - Bit 7 selects package variant; zero is the 32-pin variant.
// - Unbonded pads become inputs with pull-up after reset, eight per port.
// - Option bytes reachable only in programming mode, not by application code.
`timescale 1ns/1ns
`default_nettype none
`include "option_cfg_defs.vh"

module option_byte_clock_reset_config #(
  parameter NUM_PORTS = 4,
  parameter MASK_ROM  = 1'b0
) (
  input  wire                   i_clk_sys,
  input  wire                   i_rst,
  input  wire                   i_halt_exit,
  input  wire                   i_prog_mode,
  input  wire                   i_opt_wr,
  input  wire [7:0]             i_opt_wdata,
  input  wire                   i_readout_prot_raw,
  input  wire [NUM_PORTS*8-1:0] i_pad_bonded,
  output reg  [7:0]             o_opt_rdata,
  output reg                    o_cpu_hold,
  output reg                    o_pll_enable,
  output reg                    o_clock_source_type_ext,
  output reg                    o_source_reserved,
  output reg  [2:0]             o_osc_current_sel,
  output reg  [2:0]             o_op_freq_range,
  output reg                    o_package_select_bit,
  output reg                    o_readout_prot_en,
  output reg  [NUM_PORTS*8-1:0] o_pad_force_input,
  output reg  [NUM_PORTS*8-1:0] o_pad_force_pullup
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  // Counter width covers the long stabilisation delay
  localparam       CNT_W    = 13;

  // One-hot states of the stabilisation sequencer
  localparam [2:0] ST_RESET = 3'h1;    // Reset input asserted
  localparam [2:0] ST_COUNT = 3'h2;    // Hold counting down
  localparam [2:0] ST_RUN   = 3'h4;    // CPU released

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  // Option byte survives reset; only a programming write changes it
  reg  [7:0]       nv_byte = `OPT_DEFAULT;
  reg  [7:0]       next_nv_byte;
  reg  [7:0]       next_opt_rdata;

  // Stabilisation sequencer
  reg  [2:0]       state;
  reg  [2:0]       next_state;
  reg  [CNT_W-1:0] delay_cnt;
  reg  [CNT_W-1:0] next_delay_cnt;
  reg              next_cpu_hold;
  reg              delay_short_sel;

  // Decoded values waiting for the reset capture
  reg              next_pll_enable;
  reg              next_source_ext;
  reg              next_source_reserved;
  reg  [2:0]       next_osc_current_sel;
  reg  [2:0]       next_op_freq_range;
  reg              next_package_select_bit;
  reg              next_readout_prot_en;

  // Fields of the stored byte
  wire             short_delay;
  wire [1:0]       src;
  wire [2:0]       rng;
  wire             src_resonator;
  wire             src_external;
  wire             src_reserved;

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  // Delay bit high selects the short hold
  assign short_delay   = nv_byte[`OPT_RSTDLY_BIT];
  assign src           = nv_byte[`OPT_SRC_HI:`OPT_SRC_LO];
  assign rng           = nv_byte[`OPT_RANGE_HI:`OPT_RANGE_LO];

  // Source type; the two middle codes are reserved
  assign src_resonator = (src == `SRC_RESONATOR);
  assign src_external  = (src == `SRC_EXTERNAL);
  assign src_reserved  = ~src_resonator & ~src_external;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Hold length in cycles; the counter is loaded with one less
  function [CNT_W-1:0] delay_len;
    input sel_short;
    begin
      if (sel_short)
        delay_len = `DELAY_SHORT;
      else
        delay_len = `DELAY_LONG;
    end
  endfunction

  // Range field passed on only where it applies, else the lowest band
  function [2:0] range_if;
    input       applies;
    input [2:0] field;
    begin
      if (applies)
        range_if = field;
      else
        range_if = `RANGE_1_TO_2;
    end
  endfunction

  // ----------------------------------------
  // Programming access
  // ----------------------------------------
  // Writes and reads are honoured only in programming mode
  always @* begin
    next_nv_byte   = nv_byte;
    next_opt_rdata = `OPT_READ_IDLE;
    if (i_prog_mode) begin
      next_opt_rdata = nv_byte;
      if (i_opt_wr) begin
        next_nv_byte = i_opt_wdata;
      end
    end
  end

  // Byte storage and read port; a new byte acts only after reset
  always @(posedge i_clk_sys) begin
    nv_byte     <= next_nv_byte;
    o_opt_rdata <= next_opt_rdata;
  end

  // ----------------------------------------
  // Stabilisation sequencer
  // ----------------------------------------
  // Counts the hold after reset and after each halt exit
  always @* begin
    next_state     = state;
    next_delay_cnt = delay_cnt;
    next_cpu_hold  = o_cpu_hold;
    case (state)
      ST_RESET: begin
        next_state     = ST_COUNT;
        next_delay_cnt = delay_len(delay_short_sel) - `DELAY_STEP;
        next_cpu_hold  = 1'b1;
      end
      ST_COUNT: begin
        if (delay_cnt != `DELAY_DONE) begin
          next_delay_cnt = delay_cnt - `DELAY_STEP;
        end else begin
          next_state    = ST_RUN;
          next_cpu_hold = 1'b0;
        end
      end
      ST_RUN: begin
        next_cpu_hold = 1'b0;
      end
      default: begin
        next_state    = ST_RESET;
        next_cpu_hold = 1'b1;
      end
    endcase
    // Halt exit restarts the hold from the full count
    if (i_halt_exit) begin
      next_state     = ST_COUNT;
      next_delay_cnt = delay_len(delay_short_sel) - `DELAY_STEP;
      next_cpu_hold  = 1'b1;
    end
  end

  // Sequencer registers; reset forces the hold on at the next clock edge
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      state      <= ST_RESET;
      delay_cnt  <= `DELAY_DONE;
      o_cpu_hold <= 1'b1;
    end else begin
      state      <= next_state;
      delay_cnt  <= next_delay_cnt;
      o_cpu_hold <= next_cpu_hold;
    end
  end

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  // Values the outputs take at the next reset edge
  always @* begin
    next_pll_enable         = ~nv_byte[`OPT_PLL_OFF_BIT];
    next_source_ext         = src_external;
    next_source_reserved    = src_reserved;
    next_osc_current_sel    = range_if(src_resonator, rng);
    next_op_freq_range      = range_if(~src_resonator, rng);
    next_package_select_bit = nv_byte[`OPT_PKG_BIT];
    // Protection sense flips between mask and programmable parts
    if (MASK_ROM)
      next_readout_prot_en  = i_readout_prot_raw;
    else
      next_readout_prot_en  = ~i_readout_prot_raw;
  end

  // ----------------------------------------
  // Reset capture
  // ----------------------------------------
  // Clock path settings follow the byte only while reset is held
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pll_enable            <= next_pll_enable;
      o_clock_source_type_ext <= next_source_ext;
      o_source_reserved       <= next_source_reserved;
      o_osc_current_sel       <= next_osc_current_sel;
      o_op_freq_range         <= next_op_freq_range;
      delay_short_sel         <= short_delay;
    end
  end

  // Package and protection settings, same capture window
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_package_select_bit <= next_package_select_bit;
      o_readout_prot_en    <= next_readout_prot_en;
    end
  end

  // Unbonded pads fall back to input with pull-up after reset
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pad_force_input  <= ~i_pad_bonded;
      o_pad_force_pullup <= ~i_pad_bonded;
    end
  end

endmodule
`default_nettype wire

// File: hw/option_cfg_defs.vh
`ifndef OPTION_CFG_DEFS_VH
`define OPTION_CFG_DEFS_VH

// ----------------------------------------
// Option byte field positions
// ----------------------------------------
`define OPT_PKG_BIT       7
`define OPT_RSTDLY_BIT    6
`define OPT_SRC_HI        5
`define OPT_SRC_LO        4
`define OPT_RANGE_HI      3
`define OPT_RANGE_LO      1
`define OPT_PLL_OFF_BIT   0

// ----------------------------------------
// Encodings
// ----------------------------------------
`define SRC_RESONATOR     2'h0
`define SRC_EXTERNAL      2'h3
`define RANGE_1_TO_2      3'h0
`define RANGE_2_TO_4      3'h1
`define RANGE_4_TO_8      3'h2
`define RANGE_8_TO_16     3'h3
`define OPT_DEFAULT       8'h7F

// ----------------------------------------
// Stabilisation delays in CPU cycles
// ----------------------------------------
`define DELAY_LONG        13'h1000
`define DELAY_SHORT       13'h0100
`define DELAY_STEP        13'h0001
`define DELAY_DONE        13'h0000

// ----------------------------------------
// Read port value outside programming mode
// ----------------------------------------
`define OPT_READ_IDLE     8'h00

`endif

// File: sim/cfg_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_chk #(
  parameter NUM_PORTS = 4,
  parameter MASK_ROM  = 1'b0
) (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst,
  input wire logic                   i_halt_exit,
  input wire logic                   i_prog_mode,
  input wire logic                   i_readout_prot_raw,
  input wire logic                   o_readout_prot_en,
  input wire logic                   o_cpu_hold,
  input wire logic                   o_pll_enable,
  input wire logic                   o_clock_source_type_ext,
  input wire logic                   o_source_reserved,
  input wire logic                   o_package_select_bit,
  input wire logic [2:0]             o_osc_current_sel,
  input wire logic [2:0]             o_op_freq_range,
  input wire logic [7:0]             o_opt_rdata,
  input wire logic [NUM_PORTS*8-1:0] i_pad_bonded,
  input wire logic [NUM_PORTS*8-1:0] o_pad_force_input,
  input wire logic [NUM_PORTS*8-1:0] o_pad_force_pullup
);
  int cnt;
  // Cycles of unbroken hold since the last start
  always_ff @(posedge i_clk_sys)
    cnt <= (i_rst || !o_cpu_hold || i_halt_exit) ? 0 : cnt + 1;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_go; $fell(i_rst) or i_halt_exit; endsequence
  sequence s_held; o_cpu_hold [*8]; endsequence
  property p_hold; s_go |=> s_held; endproperty
  a_hold: assert property (p_hold) else $error("hold short");
  property p_max; cnt < 4098; endproperty
  a_max: assert property (p_max) else $error("hold long");
  property p_src; o_clock_source_type_ext |->
    !o_source_reserved && o_osc_current_sel == 0; endproperty
  a_src: assert property (p_src) else $error("source");
  property p_res; !(o_clock_source_type_ext || o_source_reserved) |->
    o_op_freq_range == 0; endproperty
  a_res: assert property (p_res) else $error("range");
  property p_rd; !i_prog_mode |=> o_opt_rdata == 0; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_keep; !$past(i_rst) |-> $stable({o_pll_enable,
    o_osc_current_sel, o_clock_source_type_ext, o_op_freq_range,
    o_package_select_bit, o_readout_prot_en}); endproperty
  a_keep: assert property (p_keep) else $error("moved");
  property p_pad; o_pad_force_input == ~i_pad_bonded; endproperty
  a_pad: assert property (p_pad) else $error("pad");
  property p_pull; o_pad_force_pullup == ~i_pad_bonded; endproperty
  a_pull: assert property (p_pull) else $error("pull");
  property p_prot; $fell(i_rst) |-> o_readout_prot_en == (MASK_ROM ?
    $past(i_readout_prot_raw) : !$past(i_readout_prot_raw)); endproperty
  a_prot: assert property (p_prot) else $error("prot");
endmodule
bind option_byte_clock_reset_config cfg_chk #(
  .NUM_PORTS (NUM_PORTS),
  .MASK_ROM  (MASK_ROM)
) u_chk (
  .i_clk_sys               (i_clk_sys),
  .i_rst                   (i_rst),
  .i_halt_exit             (i_halt_exit),
  .i_prog_mode             (i_prog_mode),
  .i_readout_prot_raw      (i_readout_prot_raw),
  .o_readout_prot_en       (o_readout_prot_en),
  .o_cpu_hold              (o_cpu_hold),
  .o_pll_enable            (o_pll_enable),
  .o_clock_source_type_ext (o_clock_source_type_ext),
  .o_source_reserved       (o_source_reserved),
  .o_package_select_bit    (o_package_select_bit),
  .o_osc_current_sel       (o_osc_current_sel),
  .o_op_freq_range         (o_op_freq_range),
  .o_opt_rdata             (o_opt_rdata),
  .i_pad_bonded            (i_pad_bonded),
  .o_pad_force_input       (o_pad_force_input),
  .o_pad_force_pullup      (o_pad_force_pullup)
);
`default_nettype wire

// File: sim/osc_model.sv
`timescale 1ns/1ns
`default_nettype none
// Source clock, still while the doubler is off
module osc_model (input wire logic i_en, output logic o_osc);
  initial o_osc = 1'b0;
  always #100 o_osc = i_en ? ~o_osc : 1'b0;
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_clk_sys, i_rst = 1, hx = 0, pm = 0, wr = 0, pll, ext, rsv, pkg, rop;
  logic hold, xo_clk, prot_raw = 0;
  logic [7:0] wd = 0, rd, b;
  logic [2:0] osc, op;
  logic [31:0] fin, fpu;
  logic [31:0] bonded = 32'hF00F_3CA5;
  int bad_count, checks, cyc;
  // Resonator bytes keep the long delay; PLL only in the 2-4 MHz band
  byte tab[8] = '{8'h02, 8'hF7, 8'h55, 8'hE5, 8'h01, 8'h05, 8'h07, 8'h75};
  option_byte_clock_reset_config dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_halt_exit(hx), .i_prog_mode(pm), .i_opt_wr(wr), .i_opt_wdata(wd),
    .i_readout_prot_raw(prot_raw), .i_pad_bonded(bonded), .o_opt_rdata(rd),
    .o_cpu_hold(hold), .o_pll_enable(pll), .o_clock_source_type_ext(ext),
    .o_source_reserved(rsv), .o_osc_current_sel(osc), .o_op_freq_range(op),
    .o_package_select_bit(pkg), .o_readout_prot_en(rop),
    .o_pad_force_input(fin), .o_pad_force_pullup(fpu));
  osc_model xo (.i_en(pll), .o_osc(xo_clk));
  initial begin
    i_clk_sys = 0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) if (++cyc > 45000) begin
    bad_count++;
    test_done;
  end
  task test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(string s, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // Count edges from the start edge until the hold drops
  task hold_n(logic [12:0] n);
    int k;
    k = 0;
    @(posedge i_clk_sys) hx <= 0;
    #1 while (hold === 1'b1 && k < 5000) begin
      @(posedge i_clk_sys) #1 k++;
    end
    chk("hold", {19'h0, n}, k);
  endtask
  // Option byte write; the strobe stands for one sampled edge
  task opt_write(logic [7:0] v, logic mode);
    @(posedge i_clk_sys) {pm, wr, wd} <= {mode, 1'b1, v};
    @(posedge i_clk_sys) wr <= 0;
  endtask
  // Option byte read; data stands on the same edge that first sees the mode
  task opt_read(string s, logic [7:0] e, logic mode);
    @(posedge i_clk_sys) pm <= mode;
    @(posedge i_clk_sys);
    #1 chk(s, {24'h0, e}, {24'h0, rd});
  endtask
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 0;
    hold_n(13'h0100);
    chk("pad_in", ~bonded, fin);
    chk("pad_pu", ~bonded, fpu);
    chk("prot", 32'h1, {31'h0, rop});
    foreach (tab[i]) begin
      b = tab[i];
      opt_write(b, 1'b1);
      opt_read("rd", b, 1'b1);
      opt_write(~b, 1'b0);
      opt_read("rd_off", 8'h00, 1'b0);
      opt_read("rd_keep", b, 1'b1);
      @(posedge i_clk_sys) {i_rst, prot_raw} <= {1'b1, b[1]};
      @(posedge i_clk_sys) i_rst <= 0;
      hold_n(b[6] ? 13'h0100 : 13'h1000);
      chk("dec", {~b[0], b[5:4] == 2'h3, ^b[5:4], b[5:4] ? 3'h0 : b[3:1],
        b[5:4] ? b[3:1] : 3'h0, b[7]}, {pll, ext, rsv, osc, op, pkg});
      chk("prot", {31'h0, ~b[1]}, {31'h0, rop});
      @(posedge i_clk_sys) hx <= 1;
      hold_n(b[6] ? 13'h0100 : 13'h1000);
    end
    test_done;
  end
endmodule
`default_nettype wire
